// File: design/rpd_field_reg.sv
// software-writable field with a reset value and a write mask
// assumes a one-cycle write strobe from the owning register decode
`timescale 1ns/100ps
module rpd_field_reg #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] RESET = '0,
  parameter logic [W-1:0] WMASK = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] q
);

  // masked bits keep their reset value forever
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET;
    end else if (we) begin
      q <= (wrData & WMASK) | (q & ~WMASK);
    end
  end

endmodule : rpd_field_reg

// File: design/rpd_power_control.sv
// power-down control of the analog, core and usb regulators, with the rtc power management register
// assumes a register master on clk, an rtc alarm level and rtc supply flag from other domains,
// and a board-strapped core regulator enable pin
`timescale 1ns/100ps
`include "rpd_map.svh"

// How it works
// [R01] one write setting either power-down bit turns off all three regulators at once
// [R02] bandgap bit (bit 2) off: regulators, analog por and bandgap; zero enables all
// [R03] regulator bit (bit 1) off: regulators and analog por; zero enables them
// [R04] during regulator power-down the bandgap stays powered for faster wake-up
// [R05] after shutdown only an rtc alarm or rtc supply power cycle re-enables
// [R06] analog regulator is always on unless a power-down bit shut it down
// [R07] board ties core enable pin low to enable, high to disable, never changed
// [R08] a disabled core or usb regulator leaves its output pin high impedance
// [R09] core regulator leaves reset enabled at 1.3 V
// [R10] software selects core output 1.3 V or 1.05 V at run time
// [R11] software enables or disables usb regulator alone, others unaffected
// [R12] usb regulator is disabled after reset
// [R13] bits 15:5 of rtc power management read constant, writes ignored
// [R14] software writes back defaults of reserved bits 4, 3 and 0
// [R15] software avoids power-down bits when the internal regulators are bypassed
// [R16] regulator control bit 1: zero gives 1.3 V, one gives 1.05 V
// [R17] regulator control bit 0: zero disables and tri-states, one enables 1.3 V
// [R18] regulator control bits 15:2 are read-only reserved, writes ignored
// [R19] an alarm wake-up clears the asserted power-down bit
module rpd_power_control
  import rpd_pkg::*;
#(
  parameter int unsigned BgSettleCycles = `RPD_BG_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`RPD_ADDR_W-1:0] addr,
  input wire logic [`RPD_DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [`RPD_DATA_W-1:0] rdData,
  input wire logic rtcAlarm,
  input wire logic rtcSupplyGood,
  input wire logic coreRegulatorEnablePin_n,
  output rpd_rail_t railOn,
  output logic coreVoltageSelect,
  output rpd_pad_oe_t padOe_n,
  output rpd_state_t powerState
);

  localparam logic [`RPD_SETTLE_W-1:0] SettleLoad = `RPD_SETTLE_W'(BgSettleCycles - 1);

  rpd_state_t state_reg;
  rpd_state_t state_next;
  logic [`RPD_SETTLE_W-1:0] settle_reg;
  logic alarmPrev_reg;
  logic supplyPrev_reg;
  logic wakeAlarm_reg;
  logic wakeSupply_reg;
  logic [`RPD_DATA_W-1:0] rdData_reg;
  rpd_rail_t railOn_reg;
  rpd_rail_t railOn_next;
  rpd_pad_oe_t padOe_reg;
  logic vsel_reg;

  logic alarmSync;
  logic supplySync;
  logic corePinSync_n;
  logic [`RPD_CTRL_W-1:0] ctrlField;

  logic hitRtcPm;
  logic hitCtrl;
  logic hitWakeStat;
  logic wrRtcPm;
  logic wrCtrl;
  logic wrWakeStat;
  logic bgReq;
  logic ldoReq;
  logic alarmRise;
  logic supplyLost;
  logic supplyBack;
  logic alarmWake;
  logic regsPowered;
  logic bgBit;
  logic ldoBit;
  logic [`RPD_DATA_W-1:0] rtcPmView;
  logic [`RPD_DATA_W-1:0] ctrlView;
  logic [`RPD_DATA_W-1:0] wakeStatView;

  // alarm and supply flag come from the rtc domain, the pin from the board
  rpd_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({rtcAlarm, rtcSupplyGood, coreRegulatorEnablePin_n}),
    .q({alarmSync, supplySync, corePinSync_n})
  );

  // bit 1 selects core voltage, bit 0 enables usb, upper bits are not stored
  rpd_field_reg #(
    .W(`RPD_CTRL_W),
    .RESET(`RPD_CTRL_RESET),
    .WMASK(`RPD_CTRL_WMASK)
  ) u_ctrl (
    .clk(clk),
    .rst(rst),
    .we(wrCtrl),
    .wrData(wrData[`RPD_CTRL_W-1:0]), // see [R18]
    .q(ctrlField)
  );

  // address decode
  assign hitRtcPm = (addr == `RPD_RTC_PM_ADDR);
  assign hitCtrl = (addr == `RPD_REG_CTRL_ADDR);
  assign hitWakeStat = (addr == `RPD_WAKE_STAT_ADDR);
  assign wrRtcPm = wrEn && hitRtcPm;
  assign wrCtrl = wrEn && hitCtrl; // see [R10] see [R11]
  assign wrWakeStat = wrEn && hitWakeStat;

  // bandgap request covers everything the regulator request does, so it takes priority
  assign bgReq = wrRtcPm && wrData[`RPD_PM_BANDGAP_POWERDOWN_BIT_BIT]; // see [R02]
  assign ldoReq = wrRtcPm && wrData[`RPD_PM_REGULATOR_POWERDOWN_BIT_BIT] && !wrData[`RPD_PM_BANDGAP_POWERDOWN_BIT_BIT]; // see [R03]

  // events from the rtc domain
  assign alarmRise = alarmSync && !alarmPrev_reg;
  assign supplyLost = !supplySync;
  assign supplyBack = supplySync && !supplyPrev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      alarmPrev_reg <= 1'h0;
      supplyPrev_reg <= 1'h0;
    end else begin
      alarmPrev_reg <= alarmSync;
      supplyPrev_reg <= supplySync;
    end
  end

  assign alarmWake = alarmRise && ((state_reg == RPD_LDO_OFF) || (state_reg == RPD_BG_OFF));

  // shutdown sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RPD_ON: begin
        if (bgReq) begin
          state_next = RPD_BG_OFF; // see [R01] see [R02]
        end else if (ldoReq) begin
          state_next = RPD_LDO_OFF; // see [R01] see [R03]
        end
      end
      RPD_LDO_OFF: begin
        // writes are ignored here; the alarm or an rtc supply loss brings the rails back
        if (alarmRise) begin
          state_next = RPD_ON; // see [R05] see [R19]
        end
      end
      RPD_BG_OFF: begin
        // bandgap must recharge its external capacitor before regulators return
        if (alarmRise) begin
          state_next = RPD_BG_WAKE; // see [R05] see [R19]
        end
      end
      RPD_BG_WAKE: begin
        if (settle_reg == '0) begin
          state_next = RPD_ON;
        end
      end
      default: begin
        state_next = RPD_ON;
      end
    endcase
    // an rtc supply power cycle acts like a fresh start of the power-down logic
    if (supplyLost) begin
      state_next = RPD_ON; // see [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= RPD_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  // bandgap settle wait after alarm wake
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_reg <= '0;
    end else if (state_reg == RPD_BG_OFF && state_next == RPD_BG_WAKE) begin
      settle_reg <= SettleLoad;
    end else if (state_reg == RPD_BG_WAKE && settle_reg != '0) begin
      settle_reg <= settle_reg - 1'b1;
    end
  end

  // wake cause flags, write one to clear; a new cause in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeAlarm_reg <= 1'h0;
    end else if (alarmWake) begin
      wakeAlarm_reg <= 1'h1;
    end else if (wrWakeStat && wrData[`RPD_WS_ALARM_BIT]) begin
      wakeAlarm_reg <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wakeSupply_reg <= 1'h0;
    end else if (supplyBack) begin
      wakeSupply_reg <= 1'h1;
    end else if (wrWakeStat && wrData[`RPD_WS_SUPPLY_BIT]) begin
      wakeSupply_reg <= 1'h0;
    end
  end

  // power-down bits are the shutdown state itself, so a wake clears them
  assign bgBit = (state_reg == RPD_BG_OFF); // see [R19]
  assign ldoBit = (state_reg == RPD_LDO_OFF); // see [R19]
  assign regsPowered = (state_reg == RPD_ON);

  // rail enables, registered so pads see no decode glitches
  always_comb begin
    railOn_next.bandgap = (state_reg != RPD_BG_OFF); // see [R02] see [R04]
    railOn_next.analogPor = regsPowered; // see [R02] see [R03]
    railOn_next.analogRegulator = regsPowered; // see [R06]
    railOn_next.coreRegulator = regsPowered && !corePinSync_n; // see [R07] see [R09]
    railOn_next.usbRegulator = regsPowered && ctrlField[`RPD_CTRL_USB_EN_BIT]; // see [R11] see [R17]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      railOn_reg <= '0;
    end else begin
      railOn_reg <= railOn_next;
    end
  end

  // pad enables are low while the regulator drives its output pin
  always_ff @(posedge clk) begin
    if (rst) begin
      padOe_reg <= '1;
    end else begin
      padOe_reg.coreRegulatorOut <= !railOn_next.coreRegulator; // see [R08]
      padOe_reg.usbRegulatorOut <= !railOn_next.usbRegulator; // see [R08] see [R17]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vsel_reg <= 1'h0; // see [R09]
    end else begin
      vsel_reg <= ctrlField[`RPD_CTRL_VSEL_BIT]; // see [R10] see [R16]
    end
  end

  // read views; reserved bits are constants and never stored
  always_comb begin
    rtcPmView = '0;
    rtcPmView[`RPD_DATA_W-1:`RPD_PM_RSVD4_BIT+1] = `RPD_PM_RSVD_HI_VAL; // see [R13]
    rtcPmView[`RPD_PM_RSVD4_BIT] = `RPD_PM_RSVD4_VAL; // see [R14]
    rtcPmView[`RPD_PM_RSVD3_BIT] = `RPD_PM_RSVD3_VAL; // see [R14]
    rtcPmView[`RPD_PM_BANDGAP_POWERDOWN_BIT_BIT] = bgBit;
    rtcPmView[`RPD_PM_REGULATOR_POWERDOWN_BIT_BIT] = ldoBit;
    rtcPmView[`RPD_PM_RSVD0_BIT] = `RPD_PM_RSVD0_VAL; // see [R14]
  end

  always_comb begin
    ctrlView = '0;
    ctrlView[`RPD_CTRL_W-1:0] = ctrlField; // see [R18]
  end

  always_comb begin
    wakeStatView = '0;
    wakeStatView[`RPD_WS_ALARM_BIT] = wakeAlarm_reg;
    wakeStatView[`RPD_WS_SUPPLY_BIT] = wakeSupply_reg;
    wakeStatView[`RPD_WS_STATE_LSB+3:`RPD_WS_STATE_LSB] = state_reg;
    wakeStatView[`RPD_WS_PIN_BIT] = corePinSync_n;
    wakeStatView[`RPD_WS_SETTLE_BIT] = (state_reg == RPD_BG_WAKE);
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= '0;
    end else if (rdEn) begin
      if (hitRtcPm) begin
        rdData_reg <= rtcPmView;
      end else if (hitCtrl) begin
        rdData_reg <= ctrlView;
      end else if (hitWakeStat) begin
        rdData_reg <= wakeStatView;
      end else begin
        rdData_reg <= '0;
      end
    end else begin
      rdData_reg <= '0;
    end
  end

  // software that bypasses the internal regulators must keep both power-down bits clear;
  // the logic cannot tell, so the request is honoured anyway (see [R15])

  assign rdData = rdData_reg;
  assign railOn = railOn_reg;
  assign padOe_n = padOe_reg;
  assign coreVoltageSelect = vsel_reg;
  assign powerState = state_reg;

endmodule : rpd_power_control

// File: design/rpd_sync.sv
// two-flop synchroniser for levels from outside the clock domain
// assumes a synchronous active-high reset; output resets to zero
`timescale 1ns/100ps
module rpd_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // the first flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : rpd_sync

// File: inc/rpd_map.svh
// register offsets, field positions, reset values and timing counts of the regulator power-down block
// assumes a 100 MHz clock and 16-bit register data
`ifndef RPD_MAP_SVH
`define RPD_MAP_SVH

`define RPD_ADDR_W 16
`define RPD_DATA_W 16

`define RPD_RTC_PM_ADDR 16'h1930
`define RPD_REG_CTRL_ADDR 16'h7004
`define RPD_WAKE_STAT_ADDR 16'h7008

`define RPD_PM_RSVD0_BIT 0
`define RPD_PM_REGULATOR_POWERDOWN_BIT_BIT 1
`define RPD_PM_BANDGAP_POWERDOWN_BIT_BIT 2
`define RPD_PM_RSVD3_BIT 3
`define RPD_PM_RSVD4_BIT 4
`define RPD_PM_RSVD_HI_VAL 11'h000
`define RPD_PM_RSVD4_VAL 1'h0
`define RPD_PM_RSVD3_VAL 1'h0
`define RPD_PM_RSVD0_VAL 1'h0

`define RPD_CTRL_USB_EN_BIT 0
`define RPD_CTRL_VSEL_BIT 1
`define RPD_CTRL_W 2
`define RPD_CTRL_RESET 2'h0
`define RPD_CTRL_WMASK 2'h3

`define RPD_WS_ALARM_BIT 0
`define RPD_WS_SUPPLY_BIT 1
`define RPD_WS_STATE_LSB 2
`define RPD_WS_PIN_BIT 6
`define RPD_WS_SETTLE_BIT 7

`define RPD_CLK_MHZ 100
`define RPD_BG_SETTLE_MS 100
`define RPD_BG_SETTLE_CYCLES (`RPD_BG_SETTLE_MS * 1000 * `RPD_CLK_MHZ)
`define RPD_SETTLE_W 24

`endif

// File: inc/rpd_pkg.sv
// types shared by the regulator power-down block
// assumes nothing from rpd_map.svh; the state codes are one-hot literals here
package rpd_pkg;

  typedef enum logic [3:0] {
    RPD_ON = 4'b0001,
    RPD_LDO_OFF = 4'b0010,
    RPD_BG_OFF = 4'b0100,
    RPD_BG_WAKE = 4'b1000
  } rpd_state_t;

  typedef struct packed {
    logic bandgap;
    logic analogPor;
    logic analogRegulator;
    logic coreRegulator;
    logic usbRegulator;
  } rpd_rail_t;

  typedef struct packed {
    logic coreRegulatorOut;
    logic usbRegulatorOut;
  } rpd_pad_oe_t;

endpackage : rpd_pkg

// File: sim/rpd_power_control_sva.sv
// port assertions for the regulator power-down block
// assumes rpd_pkg and rpd_map.svh; bound to every rpd_power_control
`timescale 1ns/100ps
`include "rpd_map.svh"
module rpd_power_control_sva
  import rpd_pkg::*;
#(
  parameter int unsigned BgSettleCycles = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`RPD_ADDR_W-1:0] addr,
  input wire logic [`RPD_DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [`RPD_DATA_W-1:0] rdData,
  input wire logic rtcAlarm,
  input wire logic rtcSupplyGood,
  input wire logic coreRegulatorEnablePin_n,
  input wire rpd_rail_t railOn,
  input wire logic coreVoltageSelect,
  input wire rpd_pad_oe_t padOe_n,
  input wire rpd_state_t powerState
);
  // a counter, not a long repetition, keeps the settle check cheap
  logic [`RPD_SETTLE_W-1:0] settleCnt_reg;
  always_ff @(posedge clk) begin
    if (rst || powerState != RPD_BG_WAKE) begin
      settleCnt_reg <= '0;
    end else begin
      settleCnt_reg <= settleCnt_reg + 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pmWrite;
    wrEn && addr == `RPD_RTC_PM_ADDR && powerState == RPD_ON;
  endsequence
  sequence ctrlWrite;
    wrEn && addr == `RPD_REG_CTRL_ADDR && powerState == RPD_ON;
  endsequence
  sequence quiet;
    (!rtcAlarm && rtcSupplyGood) [*4];
  endsequence
  a_bg_down: assert property (pmWrite ##0 wrData[2] |=>
    powerState == RPD_BG_OFF ##1 (railOn == '0 && padOe_n == 2'b11)) else $error("bandgap shutdown missed");
  a_ldo_down: assert property (pmWrite ##0 wrData[2:1] == 2'b01 |=>
    powerState == RPD_LDO_OFF ##1 railOn == 5'b10000) else $error("regulator shutdown missed");
  a_bandgap_kept: assert property (powerState inside {RPD_LDO_OFF, RPD_BG_WAKE} &&
    $past(powerState) == powerState |-> railOn == 5'b10000) else $error("bandgap not kept alone");
  a_shut_hold: assert property (quiet ##0 powerState inside {RPD_LDO_OFF, RPD_BG_OFF}
    |=> $stable(powerState)) else $error("left shutdown without wake");
  a_alarm_wake: assert property ($rose(rtcAlarm) && powerState == RPD_LDO_OFF && rtcSupplyGood
    |-> ##[1:4] powerState == RPD_ON) else $error("alarm wake missed");
  a_settle_len: assert property ($past(powerState) == RPD_BG_WAKE && powerState != RPD_BG_WAKE
    |-> settleCnt_reg == BgSettleCycles) else $error("settle length wrong");
  a_pad_tristate: assert property (padOe_n.usbRegulatorOut == !railOn.usbRegulator &&
    padOe_n.coreRegulatorOut == !railOn.coreRegulator) else $error("pad enable mismatch");
  a_usb_ctrl: assert property (ctrlWrite |-> ##2 (powerState != RPD_ON ||
    railOn.usbRegulator == $past(wrData[0], 2))) else $error("usb enable wrong");
  a_vsel_ctrl: assert property (ctrlWrite |-> ##2 coreVoltageSelect == $past(wrData[1], 2))
    else $error("voltage select wrong");
  a_on_rails: assert property (powerState == RPD_ON && $past(powerState) == RPD_ON && !$past(rst, 6) &&
    $past(coreRegulatorEnablePin_n, 4) == coreRegulatorEnablePin_n
    |-> railOn[4:1] == {3'b111, !coreRegulatorEnablePin_n}) else $error("on rails wrong");
  a_rd_idle: assert property (!$past(rdEn) |-> rdData == '0) else $error("read data not idle");
  a_pm_read: assert property (rdEn && addr == `RPD_RTC_PM_ADDR |=>
    rdData == {13'h0, $past(powerState) == RPD_BG_OFF, $past(powerState) == RPD_LDO_OFF, 1'b0})
    else $error("power management read wrong");
endmodule : rpd_power_control_sva
bind rpd_power_control rpd_power_control_sva #(.BgSettleCycles(BgSettleCycles)) uSva (.clk(clk), .rst(rst),
  .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rtcAlarm(rtcAlarm),
  .rtcSupplyGood(rtcSupplyGood), .coreRegulatorEnablePin_n(coreRegulatorEnablePin_n), .railOn(railOn),
  .coreVoltageSelect(coreVoltageSelect), .padOe_n(padOe_n), .powerState(powerState));

// File: sim/rpd_power_control_tb.sv
// self-checking bench for the regulator power-down block
// assumes the checker binds itself; the bench drives every port
`timescale 1ns/100ps
`include "rpd_map.svh"
`define RPD_CHK(g, e) begin numChecks++; if ((g) !== (e)) begin failures++; $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module rpd_power_control_tb import rpd_pkg::*;;
  localparam int unsigned SettleCycles = 12;
  logic clk, rst, wrEn, rdEn, rtcAlarm, supplyGood, corePin_n, vsel;
  logic [15:0] addr, wrData, rdData, rv;
  rpd_rail_t railOn;
  rpd_pad_oe_t padOe_n;
  rpd_state_t powerState;
  int failures, numChecks, n;
  rpd_power_control #(.BgSettleCycles(SettleCycles)) dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rtcAlarm(rtcAlarm), .rtcSupplyGood(supplyGood),
    .coreRegulatorEnablePin_n(corePin_n), .railOn(railOn), .coreVoltageSelect(vsel), .padOe_n(padOe_n),
    .powerState(powerState));
  always #5 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    rv = rdData;
  endtask : rd
  // bounded wait: a hang ends the run as a mismatch
  task automatic waitState(input rpd_state_t s);
    for (n = 0; n < 40 && powerState !== s; n++) tick(1);
    if (powerState !== s) begin
      failures++;
      $display("Error %0t: state wait timed out", $time);
      complete_run();
    end
  endtask : waitState
  task automatic doReset(input logic p);
    @(posedge clk);
    rst <= 1'b1;
    corePin_n <= p;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(8);
  endtask : doReset
  task automatic testResetAndCtrl;
    `RPD_CHK(railOn, 5'b11110)
    `RPD_CHK({padOe_n, vsel}, 3'b010)
    wr(`RPD_REG_CTRL_ADDR, 16'hffff);
    tick(1);
    `RPD_CHK({railOn, padOe_n, vsel}, 8'hf9)
    rd(`RPD_REG_CTRL_ADDR);
    `RPD_CHK(rv, 16'h0003)
    wr(`RPD_REG_CTRL_ADDR, 16'h0001);
    tick(1);
    `RPD_CHK({railOn, vsel}, 6'h3e)
    // reserved bits 4, 3 and 0 written back at their default of zero
    wr(`RPD_RTC_PM_ADDR, 16'hffe0);
    rd(`RPD_RTC_PM_ADDR);
    `RPD_CHK({rv, powerState}, {16'h0, RPD_ON})
  endtask : testResetAndCtrl
  task automatic testRegulatorDown;
    wr(`RPD_RTC_PM_ADDR, 16'h0002);
    tick(1);
    `RPD_CHK({railOn, padOe_n}, 7'h43)
    wr(`RPD_RTC_PM_ADDR, 16'h0000);
    rd(`RPD_RTC_PM_ADDR);
    `RPD_CHK({rv, powerState}, {16'h0002, RPD_LDO_OFF})
    @(posedge clk) rtcAlarm <= 1'b1;
    waitState(RPD_ON);
    @(posedge clk) rtcAlarm <= 1'b0;
    rd(`RPD_RTC_PM_ADDR);
    `RPD_CHK({rv, railOn}, {16'h0, 5'b11111})
    // alarm wake and the supply return seen after reset, state on, pin low
    rd(`RPD_WAKE_STAT_ADDR);
    `RPD_CHK(rv, 16'h0007)
    wr(`RPD_WAKE_STAT_ADDR, 16'h0003);
    rd(`RPD_WAKE_STAT_ADDR);
    `RPD_CHK(rv, 16'h0004)
  endtask : testRegulatorDown
  task automatic testBandgapDown;
    wr(`RPD_RTC_PM_ADDR, 16'h0006);
    tick(1);
    `RPD_CHK({railOn, padOe_n, powerState}, {7'h03, RPD_BG_OFF})
    @(posedge clk) rtcAlarm <= 1'b1;
    waitState(RPD_BG_WAKE);
    for (n = 1; n < 100 && powerState === RPD_BG_WAKE; n++) tick(1);
    `RPD_CHK(n - 1, SettleCycles)
    @(posedge clk) rtcAlarm <= 1'b0;
    wr(`RPD_RTC_PM_ADDR, 16'h0002);
    @(posedge clk) supplyGood <= 1'b0;
    waitState(RPD_ON);
    @(posedge clk) supplyGood <= 1'b1;
  endtask : testBandgapDown
  initial begin
    {clk, wrEn, rdEn, rtcAlarm, corePin_n, addr, wrData} = '0;
    {rst, supplyGood} = 2'b11;
    failures = 0;
    numChecks = 0;
    doReset(1'b0);
    testResetAndCtrl();
    testRegulatorDown();
    testBandgapDown();
    // a strap change is only legal across a reset; no power-down follows while the core is external
    doReset(1'b1);
    `RPD_CHK({railOn, padOe_n}, 7'h73)
    complete_run();
  end
endmodule : rpd_power_control_tb
